// [core/frc_delay_timer.sv]
// One-shot delay counter that pulses done a loaded number of cycles after the load.
`timescale 1ns/1ps
module frc_delay_timer #(
   parameter int CNT_W = 12
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [CNT_W-1:0] load_value,
   output logic done
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic run;
      logic done;
   } frc_tmr_t;

   frc_tmr_t r;
   frc_tmr_t n;

   generate
      if (CNT_W < 2) begin : g_bad_width
         $error("Timer width too small.");
      end
   endgenerate

   always_comb begin
      n = r;
      n.done = 1'b0;
      if (load) begin
         n.cnt = load_value;
         n.run = 1'b1;
      end else if (r.run) begin
         if (r.cnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
            n.run = 1'b0;
            n.done = 1'b1;
         end else begin
            n.cnt = r.cnt - {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign done = r.done;
endmodule // frc_delay_timer

// [core/frc_flash_rewrite_control.sv]
// Register file and rewrite sequencer for the on-chip flash.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module frc_flash_rewrite_control #(
   parameter int ABORT_CYCLES = frc_pkg::ABORT_CYCLES_DEF,
   parameter int RESTART_CYCLES = frc_pkg::RESTART_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic cmd_valid,
   input wire frc_pkg::frc_cmd_t cmd_kind,
   input wire frc_pkg::frc_block_t cmd_block,
   input wire logic core_done,
   input wire logic core_prog_err,
   input wire logic core_erase_err,
   input wire logic core_seq_err,
   input wire logic core_suspend_ack,
   input wire logic busy_access,
   input wire logic low_power_req,
   output logic core_start,
   output frc_pkg::frc_cmd_t core_kind,
   output frc_pkg::frc_block_t core_block,
   output logic core_abort,
   output logic ctrl_reinit,
   output logic flash_read_en,
   output logic flash_power_off,
   output logic lock_enforce,
   output logic lock_bit_clear,
   output logic irq_cmd_error,
   output logic irq_access_error,
   output logic irq_ready
);
   import frc_pkg::*;

   localparam int ABORT_MAX = ABORT_CYCLES + 3;

   generate
      if (ABORT_CYCLES < 1 || ABORT_CYCLES >= (1 << CNT_W) || RESTART_CYCLES < 1 ||
          RESTART_CYCLES >= (1 << CNT_W)) begin : g_bad_delay
         $error("Delay counts do not fit the timer.");
      end
   endgenerate

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      frc_fsm_t state;
      logic ready_req;
      logic acc_err_req;
      logic cmd_err_pend;
      logic prog_err;
      logic erase_err;
      logic erase_susp;
      logic cpu_rewrite;
      logic ew1;
      logic power_down;
      logic auto_off;
      logic cmd_err_ie;
      logic acc_err_ie;
      logic ready_ie;
      logic lock_override;
      logic inhibit_a;
      logic inhibit_b;
      logic arm_lock;
      logic arm_a;
      logic arm_b;
      frc_cmd_t cur_kind;
      logic [7:0] rdata;
      logic start;
      frc_cmd_t start_kind;
      frc_block_t start_block;
      logic abort;
      logic reinit;
      logic read_en;
      logic power_off;
      logic lock_clear;
      logic lock_on;
      logic tmr_load;
      logic [CNT_W-1:0] tmr_value;
   } frc_top_t;

   frc_top_t r;
   frc_top_t n;
   logic tmr_done;
   logic wr_op;
   logic wr_prot;
   logic wr_stat;
   logic abort_req;
   logic go_ready;
   logic any_err;

   frc_delay_timer #(
      .CNT_W(CNT_W)
   ) u_timer (
      .clk(clk),
      .rst(rst),
      .load(r.tmr_load),
      .load_value(r.tmr_value),
      .done(tmr_done)
   );

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      n = r;
      n.start = 1'b0;
      n.abort = 1'b0;
      n.reinit = 1'b0;
      n.lock_clear = 1'b0;
      n.tmr_load = 1'b0;
      go_ready = 1'b0;
      wr_op = reg_wr && (reg_addr == FRC_ADDR_OP_CTRL);
      wr_prot = reg_wr && (reg_addr == FRC_ADDR_PROTECT);
      wr_stat = reg_wr && (reg_addr == FRC_ADDR_STATUS);
      // Abort counts only in rewrite mode, while busy or erase-suspended.
      abort_req = wr_op && reg_wdata[OP_ABORT_BIT] && r.cpu_rewrite &&
                  ((r.state == FSM_BUSY) || r.erase_susp);
      any_err = core_prog_err || core_erase_err || core_seq_err;

      // Request flags take only a zero from software; hardware sets come later and win.
      if (wr_stat) begin
         if (!reg_wdata[ST_READY_REQ_BIT]) begin
            n.ready_req = 1'b0;
         end
         if (!reg_wdata[ST_ACC_ERR_BIT]) begin
            n.acc_err_req = 1'b0;
         end
      end

      if (wr_op) begin
         n.cpu_rewrite = reg_wdata[OP_REWRITE_BIT];
         n.ew1 = reg_wdata[OP_EW1_BIT];
         n.cmd_err_ie = reg_wdata[OP_CMD_ERR_IE_BIT];
         n.acc_err_ie = reg_wdata[OP_ACC_ERR_IE_BIT];
         n.ready_ie = reg_wdata[OP_READY_IE_BIT];
         if (r.cpu_rewrite) begin
            n.power_down = reg_wdata[OP_POWER_DOWN_BIT];
            if (reg_wdata[OP_POWER_DOWN_BIT] && !r.power_down) begin
               n.lock_override = 1'b0;
            end
         end
      end

      // The arming bits remember only the write just before, so any other write disarms.
      if (reg_wr) begin
         n.arm_lock = wr_prot && !reg_wdata[PR_LOCK_OVR_BIT];
         n.arm_a = wr_prot && reg_wdata[PR_INHIBIT_A_BIT];
         n.arm_b = wr_prot && reg_wdata[PR_INHIBIT_B_BIT];
      end
      if (wr_prot) begin
         n.lock_override = reg_wdata[PR_LOCK_OVR_BIT] && (r.lock_override || r.arm_lock);
         n.inhibit_a = reg_wdata[PR_INHIBIT_A_BIT] || (r.inhibit_a && !r.arm_a);
         n.inhibit_b = reg_wdata[PR_INHIBIT_B_BIT] || (r.inhibit_b && !r.arm_b);
      end

      case (r.state)
         FSM_READY: begin
            if (r.power_down) begin
               n.state = FSM_OFF;
               n.reinit = 1'b1;
            end else if (low_power_req && !r.cpu_rewrite) begin
               n.state = FSM_OFF;
               n.auto_off = 1'b1;
            end else if (abort_req) begin
               n.state = FSM_ABORT;
            end else if (cmd_valid && r.cpu_rewrite) begin
               if (cmd_kind == CMD_CLEAR_STATUS) begin
                  n.prog_err = 1'b0;
                  n.erase_err = 1'b0;
                  n.acc_err_req = 1'b0;
                  n.cmd_err_pend = 1'b0;
               end else if (!((cmd_kind != CMD_BLANK_CHECK) &&
                              (((cmd_block == BLK_DATA_A) && r.inhibit_a) ||
                               ((cmd_block == BLK_DATA_B) && r.inhibit_b)))) begin
                  n.state = FSM_BUSY;
                  n.start = 1'b1;
                  n.start_kind = cmd_kind;
                  n.start_block = cmd_block;
                  n.cur_kind = cmd_kind;
                  if (cmd_kind == CMD_ERASE) begin
                     n.erase_susp = 1'b0;
                  end
               end
            end
         end
         FSM_BUSY: begin
            if (abort_req) begin
               n.state = FSM_ABORT;
            end else if (core_suspend_ack) begin
               n.state = FSM_READY;
               n.erase_susp = 1'b1;
               n.lock_override = 1'b0;
               go_ready = 1'b1;
            end else if (core_done || any_err) begin
               n.state = FSM_READY;
               go_ready = 1'b1;
               n.lock_override = 1'b0;
               n.lock_clear = core_done && (r.cur_kind == CMD_ERASE) && r.lock_override;
            end
         end
         FSM_ABORT: begin
            if (tmr_done) begin
               n.state = FSM_READY;
               go_ready = 1'b1;
            end
         end
         FSM_OFF: begin
            if ((r.auto_off && !low_power_req) || (!r.auto_off && !r.power_down)) begin
               n.state = FSM_RESTART;
               n.auto_off = 1'b0;
               n.tmr_load = 1'b1;
               n.tmr_value = CNT_W'(RESTART_CYCLES);
            end
         end
         FSM_RESTART: begin
            if (tmr_done) begin
               n.state = FSM_READY;
               go_ready = 1'b1;
            end
         end
         default: begin
            n.state = FSM_READY;
         end
      endcase

      // Abort reinitialises the sequence, drops the suspend and starts the settle delay.
      if (abort_req) begin
         n.abort = 1'b1;
         n.reinit = 1'b1;
         n.erase_susp = 1'b0;
         n.lock_override = 1'b0;
         n.tmr_load = 1'b1;
         n.tmr_value = CNT_W'(ABORT_CYCLES);
      end

      if (core_prog_err) begin
         n.prog_err = 1'b1;
      end
      if (core_erase_err) begin
         n.erase_err = 1'b1;
      end
      if (core_seq_err) begin
         n.prog_err = 1'b1;
         n.erase_err = 1'b1;
         n.lock_override = 1'b0;
      end
      if (any_err && r.cmd_err_ie) begin
         n.cmd_err_pend = 1'b1;
         n.acc_err_req = 1'b1;
      end
      if (busy_access && r.acc_err_ie && (r.state == FSM_BUSY)) begin
         n.acc_err_req = 1'b1;
      end
      if (go_ready && r.ready_ie) begin
         n.ready_req = 1'b1;
      end

      if (!n.cpu_rewrite) begin
         n.inhibit_a = 1'b0;
         n.inhibit_b = 1'b0;
         n.lock_override = 1'b0;
      end

      n.read_en = (n.state == FSM_READY) || (n.state == FSM_BUSY);
      n.power_off = (n.state == FSM_OFF);
      n.lock_on = !n.lock_override;

      n.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            FRC_ADDR_STATUS: begin
               n.rdata[ST_READY_REQ_BIT] = r.ready_req;
               n.rdata[ST_ACC_ERR_BIT] = r.acc_err_req;
               n.rdata[ST_PROG_ERR_BIT] = r.prog_err;
               n.rdata[ST_ERASE_ERR_BIT] = r.erase_err;
               n.rdata[ST_ERASE_SUSP_BIT] = r.erase_susp;
               n.rdata[ST_READY_BIT] = (r.state == FSM_READY);
            end
            FRC_ADDR_OP_CTRL: begin
               n.rdata[OP_REWRITE_BIT] = r.cpu_rewrite;
               n.rdata[OP_EW1_BIT] = r.ew1;
               n.rdata[OP_POWER_DOWN_BIT] = r.power_down;
               n.rdata[OP_ABORT_BIT] = 1'b0;
               n.rdata[OP_CMD_ERR_IE_BIT] = r.cmd_err_ie;
               n.rdata[OP_ACC_ERR_IE_BIT] = r.acc_err_ie;
               n.rdata[OP_READY_IE_BIT] = r.ready_ie;
            end
            FRC_ADDR_PROTECT: begin
               n.rdata[PR_LOCK_OVR_BIT] = r.lock_override;
               n.rdata[PR_INHIBIT_A_BIT] = r.inhibit_a;
               n.rdata[PR_INHIBIT_B_BIT] = r.inhibit_b;
            end
            default: begin
               n.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
         r.read_en <= 1'b1;
         r.lock_on <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign reg_rdata = r.rdata;
   assign core_start = r.start;
   assign core_kind = r.start_kind;
   assign core_block = r.start_block;
   assign core_abort = r.abort;
   assign ctrl_reinit = r.reinit;
   assign flash_read_en = r.read_en;
   assign flash_power_off = r.power_off;
   assign lock_enforce = r.lock_on;
   assign lock_bit_clear = r.lock_clear;
   assign irq_cmd_error = r.cmd_err_pend;
   assign irq_access_error = r.acc_err_req;
   assign irq_ready = r.ready_req;

   // ==========================================================
   // Checks
   // ==========================================================
   a_abort_reads_zero: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == FRC_ADDR_OP_CTRL) |=> !reg_rdata[OP_ABORT_BIT])
      else $error("Abort bit read back as one.");

   a_abort_read_back: assert property (@(posedge clk) disable iff (rst)
      $rose(core_abort) |-> !flash_read_en ##[1:ABORT_MAX] flash_read_en)
      else $error("Reads not re-enabled after abort delay.");

   a_power_down_off: assert property (@(posedge clk) disable iff (rst)
      (r.power_down && r.state == FSM_READY) |=> (flash_power_off && !flash_read_en && ctrl_reinit))
      else $error("Power-down did not stop the flash.");

   a_auto_power_off: assert property (@(posedge clk) disable iff (rst)
      (r.state == FSM_READY && low_power_req && !r.cpu_rewrite && !r.power_down) |=> flash_power_off)
      else $error("Stop entry did not power the flash off.");

   a_cmd_needs_mode: assert property (@(posedge clk) disable iff (rst)
      core_start |-> $past(r.cpu_rewrite) && $past(r.state) == FSM_READY)
      else $error("Command started outside rewrite mode.");

   a_inhibit_ignores: assert property (@(posedge clk) disable iff (rst)
      (core_start && core_kind != CMD_BLANK_CHECK && core_block == BLK_DATA_A) |-> !$past(r.inhibit_a))
      else $error("Command started on inhibited block.");

   a_cmd_err_irq: assert property (@(posedge clk) disable iff (rst)
      (any_err && r.cmd_err_ie) |=> irq_cmd_error && irq_access_error)
      else $error("Command error raised no interrupt.");

   a_ready_irq: assert property (@(posedge clk) disable iff (rst)
      (r.ready_ie && r.state == FSM_BUSY && core_done && !abort_req) |=> irq_ready && r.state == FSM_READY)
      else $error("Busy-to-ready raised no interrupt.");

   a_override_seq: assert property (@(posedge clk) disable iff (rst)
      $rose(r.lock_override) |-> $past(wr_prot && reg_wdata[PR_LOCK_OVR_BIT] && r.arm_lock))
      else $error("Override set without zero-one sequence.");

   a_override_clears: assert property (@(posedge clk) disable iff (rst)
      (core_abort || lock_bit_clear || !r.cpu_rewrite) |-> !r.lock_override)
      else $error("Override survived a clearing event.");

   a_inhibit_mode: assert property (@(posedge clk) disable iff (rst)
      !r.cpu_rewrite |-> !r.inhibit_a && !r.inhibit_b)
      else $error("Inhibit held with rewrite mode off.");
endmodule // frc_flash_rewrite_control

// [core/frc_pkg.sv]
// Shared constants and types for the flash rewrite control block.
package frc_pkg;

   // ==========================================================
   // Register addresses
   // ==========================================================
   localparam logic [15:0] FRC_ADDR_STATUS = 16'h01B3;
   localparam logic [15:0] FRC_ADDR_OP_CTRL = 16'h01B4;
   localparam logic [15:0] FRC_ADDR_PROTECT = 16'h01B5;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int ST_READY_REQ_BIT = 0;
   localparam int ST_ACC_ERR_BIT = 1;
   localparam int ST_PROG_ERR_BIT = 4;
   localparam int ST_ERASE_ERR_BIT = 5;
   localparam int ST_ERASE_SUSP_BIT = 6;
   localparam int ST_READY_BIT = 7;
   localparam int OP_REWRITE_BIT = 1;
   localparam int OP_EW1_BIT = 2;
   localparam int OP_POWER_DOWN_BIT = 3;
   localparam int OP_ABORT_BIT = 4;
   localparam int OP_CMD_ERR_IE_BIT = 5;
   localparam int OP_ACC_ERR_IE_BIT = 6;
   localparam int OP_READY_IE_BIT = 7;
   localparam int PR_LOCK_OVR_BIT = 3;
   localparam int PR_INHIBIT_A_BIT = 4;
   localparam int PR_INHIBIT_B_BIT = 5;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0] FRC_OP_CTRL_RESET = 8'h00;
   localparam logic [7:0] FRC_PROTECT_RESET = 8'h00;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_PERIOD_NS = 10;
   localparam int ABORT_DELAY_NS = 1000;
   localparam int RESTART_DELAY_NS = 500;
   localparam int ABORT_CYCLES_DEF = (ABORT_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 : ABORT_DELAY_NS / CLK_PERIOD_NS;
   localparam int RESTART_CYCLES_DEF = (RESTART_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                       RESTART_DELAY_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 12;

   // ==========================================================
   // Commands, target blocks and sequencer states
   // ==========================================================
   typedef enum logic [1:0] {
      CMD_PROGRAM = 2'b00,
      CMD_ERASE = 2'b01,
      CMD_CLEAR_STATUS = 2'b10,
      CMD_BLANK_CHECK = 2'b11
   } frc_cmd_t;

   typedef enum logic [1:0] {
      BLK_PROGRAM = 2'b00,
      BLK_DATA_A = 2'b01,
      BLK_DATA_B = 2'b10,
      BLK_OTHER = 2'b11
   } frc_block_t;

   typedef enum logic [2:0] {
      FSM_READY = 3'b000,
      FSM_BUSY = 3'b001,
      FSM_ABORT = 3'b010,
      FSM_OFF = 3'b011,
      FSM_RESTART = 3'b100
   } frc_fsm_t;

endpackage

// [test/frc_core_model.sv]
// Behavioural flash core that answers a start with done, an error or a suspend acknowledge.
`timescale 1ns/1ps
module frc_core_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic core_start,
   input wire logic core_abort,
   input wire logic [1:0] mode,
   input wire logic [7:0] dly,
   output logic core_done,
   output logic core_prog_err,
   output logic core_seq_err,
   output logic core_suspend_ack
);
   logic [7:0] cnt_r;

   // Mode 0 ends normally, 1 with a program error, 2 with a suspend acknowledge, 3 with a sequence error.
   always @(posedge clk) begin
      core_done <= 1'b0;
      core_prog_err <= 1'b0;
      core_seq_err <= 1'b0;
      core_suspend_ack <= 1'b0;
      if (rst || core_abort) begin
         cnt_r <= 8'h00;
      end else if (core_start) begin
         cnt_r <= dly;
      end else if (cnt_r == 8'h01) begin
         cnt_r <= 8'h00;
         core_done <= (mode == 2'h0);
         core_prog_err <= (mode == 2'h1);
         core_suspend_ack <= (mode == 2'h2);
         core_seq_err <= (mode == 2'h3);
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end
endmodule // frc_core_model

// [test/tb_flash_rewrite_control.sv]
// Self-checking bench for the flash rewrite control block.
`timescale 1ns/1ps
module tb_flash_rewrite_control;
   import frc_pkg::*;
   localparam int AB = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic cmd_valid = 1'b0;
   frc_cmd_t cmd_kind = CMD_PROGRAM;
   frc_block_t cmd_block = BLK_PROGRAM;
   logic busy_access = 1'b0;
   logic low_power_req = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [7:0] dly = 8'h08;
   logic [7:0] reg_rdata, v, s;
   logic core_done, core_prog_err, core_seq_err, core_suspend_ack, core_start, core_abort, ctrl_reinit;
   logic flash_read_en, flash_power_off, lock_enforce, lock_bit_clear, irq_cmd_error, irq_access_error, irq_ready;
   frc_cmd_t core_kind;
   frc_block_t core_block;
   logic [7:0] n_start = 8'h00, n_abort = 8'h00, n_reinit = 8'h00, n_lbc = 8'h00;
   logic [31:0] seed = 32'd71;
   logic [31:0] r;
   int fails = 0;
   int checks_done = 0;
   int cycles = 0;
   int k;

   always #5 clk = ~clk;

   frc_flash_rewrite_control #(.ABORT_CYCLES(AB), .RESTART_CYCLES(3)) frc_flash_rewrite_control_inst (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_block(cmd_block),
      .core_done(core_done), .core_prog_err(core_prog_err), .core_erase_err(1'b0), .core_seq_err(core_seq_err),
      .core_suspend_ack(core_suspend_ack), .busy_access(busy_access), .low_power_req(low_power_req),
      .core_start(core_start), .core_kind(core_kind), .core_block(core_block), .core_abort(core_abort),
      .ctrl_reinit(ctrl_reinit), .flash_read_en(flash_read_en), .flash_power_off(flash_power_off),
      .lock_enforce(lock_enforce), .lock_bit_clear(lock_bit_clear), .irq_cmd_error(irq_cmd_error),
      .irq_access_error(irq_access_error), .irq_ready(irq_ready));

   frc_core_model frc_core_model_inst (.clk(clk), .rst(rst), .core_start(core_start), .core_abort(core_abort),
      .mode(mode), .dly(dly), .core_done(core_done), .core_prog_err(core_prog_err), .core_seq_err(core_seq_err),
      .core_suspend_ack(core_suspend_ack));

   // ==========================================================
   // Pulse monitors and timeout
   // ==========================================================
   always @(posedge clk) begin
      n_start <= n_start + {7'h00, core_start === 1'b1};
      n_abort <= n_abort + {7'h00, core_abort === 1'b1};
      n_reinit <= n_reinit + {7'h00, ctrl_reinit === 1'b1};
      n_lbc <= n_lbc + {7'h00, lock_bit_clear === 1'b1};
      cycles++;
      if (cycles == 20000) begin
         fails++;
         summarize();
      end
   end

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic cmd(input frc_cmd_t c, input frc_block_t b);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_kind <= c;
      cmd_block <= b;
      @(posedge clk);
      cmd_valid <= 1'b0;
   endtask

   // Polls the ready flag so that slow commands never hang the run.
   task automatic wait_rdy();
      v = 8'h00;
      for (k = 0; k < 60 && v[ST_READY_BIT] !== 1'b1; k++) begin
         rd(FRC_ADDR_STATUS, v);
      end
   endtask

   task automatic summarize();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(FRC_ADDR_OP_CTRL, v);
      chk("op_reset", FRC_OP_CTRL_RESET, v);
      rd(FRC_ADDR_PROTECT, v);
      chk("prot_reset", FRC_PROTECT_RESET, v);
      rd(FRC_ADDR_STATUS, v);
      chk("status_idle", 8'h80, v);
      for (int i = 0; i < 4; i++) begin
         r = xs();
         wr({8'h02, r[7:0]}, r[15:8]);
         rd({8'h02, r[7:0]}, v);
         chk("unmapped", 8'h00, v);
      end
      s = n_start;
      cmd(CMD_PROGRAM, BLK_PROGRAM);
      repeat (2) @(posedge clk);
      chk("start_rewrite_off", s, n_start);
      wr(FRC_ADDR_OP_CTRL, 8'h00);
      wr(FRC_ADDR_OP_CTRL, 8'h02);
      wr(FRC_ADDR_PROTECT, 8'h08);
      rd(FRC_ADDR_PROTECT, v);
      chk("override_single", 8'h00, v);
      wr(FRC_ADDR_PROTECT, 8'h00);
      wr(FRC_ADDR_PROTECT, 8'h08);
      rd(FRC_ADDR_PROTECT, v);
      chk("override_pair", 8'h08, v);
      chk("lock_enforce", 8'h00, lock_enforce);
      rd(FRC_ADDR_STATUS, v);
      wr(FRC_ADDR_STATUS, 8'h00);
      wr(FRC_ADDR_OP_CTRL, 8'h82);
      r = xs();
      dly <= 8'h04 + {5'h00, r[2:0]};
      s = n_lbc;
      cmd(CMD_ERASE, BLK_PROGRAM);
      rd(FRC_ADDR_STATUS, v);
      chk("busy_flag", 8'h00, v & 8'h80);
      wait_rdy();
      repeat (2) @(posedge clk);
      chk("lock_clear", s + 8'h01, n_lbc);
      rd(FRC_ADDR_PROTECT, v);
      chk("override_auto_clr", 8'h00, v);
      chk("irq_ready", 8'h01, irq_ready);
      wr(FRC_ADDR_STATUS, 8'h00);
      wr(FRC_ADDR_PROTECT, 8'h10);
      s = n_start;
      cmd(CMD_PROGRAM, BLK_DATA_A);
      repeat (2) @(posedge clk);
      chk("inhibit_start", s, n_start);
      rd(FRC_ADDR_STATUS, v);
      chk("inhibit_no_err", 8'h80, v);
      s = n_start;
      cmd(CMD_BLANK_CHECK, BLK_DATA_A);
      wait_rdy();
      chk("blank_on_inhibit", s + 8'h01, n_start);
      wr(FRC_ADDR_PROTECT, 8'h00);
      rd(FRC_ADDR_PROTECT, v);
      chk("inhibit_pair", 8'h00, v);
      wr(FRC_ADDR_PROTECT, 8'h30);
      wr(FRC_ADDR_OP_CTRL, 8'h80);
      rd(FRC_ADDR_PROTECT, v);
      chk("inhibit_rewrite_off", 8'h00, v);
      wr(FRC_ADDR_OP_CTRL, 8'h82);
      dly <= 8'h3C;
      s = n_abort;
      cmd(CMD_ERASE, BLK_DATA_B);
      wr(FRC_ADDR_OP_CTRL, 8'h92);
      @(posedge clk);
      #1;
      chk("abort_read_block", 8'h00, flash_read_en);
      chk("core_kind", {6'h00, CMD_ERASE}, {6'h00, core_kind});
      chk("core_block", {6'h00, BLK_DATA_B}, {6'h00, core_block});
      for (k = 0; k < AB + 3 && flash_read_en !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      chk("abort_read_back", 8'h01, flash_read_en);
      chk("abort_pulse", s + 8'h01, n_abort);
      rd(FRC_ADDR_OP_CTRL, v);
      chk("abort_reads_zero", 8'h82, v);
      cmd(CMD_CLEAR_STATUS, BLK_PROGRAM);
      mode <= 2'h2;
      dly <= 8'h06;
      cmd(CMD_ERASE, BLK_PROGRAM);
      wait_rdy();
      chk("suspended", 8'hC0, v & 8'hC0);
      wr(FRC_ADDR_OP_CTRL, 8'h92);
      wait_rdy();
      chk("suspend_abort", 8'h80, v & 8'hC0);
      cmd(CMD_CLEAR_STATUS, BLK_PROGRAM);
      wr(FRC_ADDR_OP_CTRL, 8'hA2);
      mode <= 2'h1;
      cmd(CMD_PROGRAM, BLK_DATA_B);
      wait_rdy();
      chk("irq_cmd_err", 8'h01, irq_cmd_error);
      chk("prog_err_bit", 8'h10, v & 8'h10);
      wr(FRC_ADDR_PROTECT, 8'h00);
      wr(FRC_ADDR_PROTECT, 8'h08);
      rd(FRC_ADDR_PROTECT, v);
      chk("override_again", 8'h08, v);
      mode <= 2'h3;
      cmd(CMD_ERASE, BLK_PROGRAM);
      wait_rdy();
      chk("seq_err_status", 8'hB2, v & 8'hFE);
      chk("seq_err_irq", 8'h01, irq_cmd_error);
      rd(FRC_ADDR_PROTECT, v);
      chk("seq_err_override", 8'h00, v);
      cmd(CMD_CLEAR_STATUS, BLK_PROGRAM);
      @(posedge clk);
      #1;
      chk("irq_cmd_clear", 8'h00, irq_cmd_error);
      rd(FRC_ADDR_STATUS, v);
      wr(FRC_ADDR_STATUS, 8'h00);
      wr(FRC_ADDR_OP_CTRL, 8'h42);
      mode <= 2'h0;
      dly <= 8'h0C;
      cmd(CMD_ERASE, BLK_DATA_A);
      busy_access <= 1'b1;
      @(posedge clk);
      busy_access <= 1'b0;
      wait_rdy();
      chk("irq_access", 8'h01, irq_access_error);
      s = n_reinit;
      wr(FRC_ADDR_OP_CTRL, 8'h0A);
      repeat (3) @(posedge clk);
      chk("power_off", 8'h01, flash_power_off);
      chk("power_read_block", 8'h00, flash_read_en);
      chk("power_reinit", s + 8'h01, n_reinit);
      wr(FRC_ADDR_OP_CTRL, 8'h02);
      wait_rdy();
      chk("power_on", 8'h00, flash_power_off);
      wr(FRC_ADDR_OP_CTRL, 8'h00);
      low_power_req <= 1'b1;
      repeat (3) @(posedge clk);
      chk("auto_off", 8'h01, flash_power_off);
      low_power_req <= 1'b0;
      wait_rdy();
      chk("auto_on", 8'h00, flash_power_off);
      summarize();
   end
endmodule // tb_flash_rewrite_control
